// [src/bpio_pkg.sv]
// package for the bit-programmable i/o ports block
// assumes an 8-bit special register space addressed by the core
package bpio_pkg;

  // ----------------------------------------------------------------
  // register locations
  // ----------------------------------------------------------------
  localparam logic [7:0] BPIO_PORT0_DATA_ADDR = 8'hE0;
  localparam logic [7:0] BPIO_PORT1_DATA_ADDR = 8'hE1;
  localparam logic [7:0] BPIO_PORT2_DATA_ADDR = 8'hE2;
  localparam logic [7:0] BPIO_PORT3_DATA_ADDR = 8'hE3;
  localparam logic [7:0] BPIO_PORT0_CFG_ADDR = 8'hE6;
  localparam logic [7:0] BPIO_PORT1_UPPER_CFG_ADDR = 8'hE8;
  localparam logic [7:0] BPIO_PORT1_LOWER_CFG_ADDR = 8'hE9;
  localparam logic [7:0] BPIO_PORT1_IRQ_EN_ADDR = 8'hEA;
  localparam logic [7:0] BPIO_PORT1_IRQ_PEND_ADDR = 8'hEB;
  localparam logic [7:0] BPIO_PORT2_UPPER_CFG_ADDR = 8'hFC;
  localparam logic [7:0] BPIO_PORT2_LOWER_CFG_ADDR = 8'hFD;
  localparam logic [7:0] BPIO_PORT3_UPPER_CFG_ADDR = 8'hF6;
  localparam logic [7:0] BPIO_PORT3_LOWER_CFG_ADDR = 8'hF7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BPIO_CFG_RESET = 8'h00;
  localparam logic [7:0] BPIO_DATA_RESET = 8'h00;
  localparam logic [3:0] BPIO_IRQ_RESET = 4'h0;
  localparam logic [7:0] BPIO_READ_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // field layout and pin mode codes
  // ----------------------------------------------------------------
  localparam int BPIO_FIELD_W = 2;
  localparam int BPIO_P1_UPPER_USED_W = 4;
  localparam int BPIO_IRQ_PINS = 4;
  localparam logic [1:0] BPIO_MODE_INPUT = 2'h0;
  localparam logic [1:0] BPIO_MODE_PULLUP = 2'h1;
  localparam logic [1:0] BPIO_MODE_PUSHPULL = 2'h2;
  localparam logic [1:0] BPIO_MODE_ALT = 2'h3;

endpackage : bpio_pkg

// [src/bpio_ports.sv]
// bit-programmable i/o ports: data, pin config, port 1 edge interrupts
// assumes the core's register strobes are synchronous to ref_clk; pin inputs go through two-flop synchronisers
`timescale 1ns/1ps
`default_nettype none

module bpio_ports
  import bpio_pkg::*;
#(
  parameter int P0_W = 4,
  parameter int P1_W = 6,
  parameter int P2_W = 8,
  parameter int P3_W = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  input wire logic [P0_W-1:0] port0_pin_in,
  output logic [P0_W-1:0] port0_pin_out,
  output logic [P0_W-1:0] port0_pin_oe,
  output logic [P0_W-1:0] port0_pullup_en,
  output logic [P0_W-1:0] analog_channels_low_en,
  input wire logic [P1_W-1:0] port1_pin_in,
  output logic [P1_W-1:0] port1_pin_out,
  output logic [P1_W-1:0] port1_pin_oe,
  output logic [P1_W-1:0] port1_pullup_en,
  output logic analog_channel_5_en,
  output logic analog_channel_6_en,
  input wire logic timer_a_output,
  input wire logic buzzer_output,
  input wire logic timer1_output_zero,
  output logic timer_a_clock_input,
  output logic timer_a_capture_input,
  output logic timer1_clock_input,
  output logic timer1_capture_input,
  output logic [BPIO_IRQ_PINS-1:0] external_irq_n,
  input wire logic [P2_W-1:0] port2_pin_in,
  input wire logic [P2_W-1:0] port2_alt_out,
  output logic [P2_W-1:0] port2_pin_out,
  output logic [P2_W-1:0] port2_pin_oe,
  output logic [P2_W-1:0] port2_pullup_en,
  input wire logic [P3_W-1:0] port3_pin_in,
  output logic [P3_W-1:0] port3_pin_out,
  output logic [P3_W-1:0] port3_pin_oe,
  output logic [P3_W-1:0] port3_pullup_en
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // picks the 2-bit mode field of one pin out of a packed config word
  function automatic logic [1:0] bpio_field(input logic [15:0] cfg, input int idx);
    bpio_field = cfg[idx*BPIO_FIELD_W +: BPIO_FIELD_W];
  endfunction : bpio_field

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [P0_W-1:0] port0_data_reg;
  logic [P1_W-1:0] port1_data_reg;
  logic [P2_W-1:0] port2_data_reg;
  logic [P3_W-1:0] port3_data_reg;
  logic [7:0] port0_pin_config_reg;
  logic [BPIO_P1_UPPER_USED_W-1:0] port1_upper_pin_config_reg;
  logic [7:0] port1_lower_pin_config_reg;
  logic [BPIO_IRQ_PINS-1:0] port1_irq_enable_reg;
  logic [BPIO_IRQ_PINS-1:0] port1_irq_pending_reg;
  logic [15:0] port2_pin_config_reg;
  logic [15:0] port3_pin_config_reg;
  logic [P0_W-1:0] port0_sync1_reg;
  logic [P0_W-1:0] port0_sync2_reg;
  logic [P1_W-1:0] port1_sync1_reg;
  logic [P1_W-1:0] port1_sync2_reg;
  logic [P1_W-1:0] port1_prev_reg;
  logic [P2_W-1:0] port2_sync1_reg;
  logic [P2_W-1:0] port2_sync2_reg;
  logic [P3_W-1:0] port3_sync1_reg;
  logic [P3_W-1:0] port3_sync2_reg;

  logic [15:0] port0_cfg_word;
  logic [15:0] port1_cfg_word;
  logic [BPIO_IRQ_PINS-1:0] irq_edge;
  logic [BPIO_IRQ_PINS-1:0] pending_next;
  logic [7:0] rd_data_next;

  assign port0_cfg_word = {8'h00, port0_pin_config_reg};
  assign port1_cfg_word = {4'h0, port1_upper_pin_config_reg, port1_lower_pin_config_reg};

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port0_pin_config_reg <= BPIO_CFG_RESET;
      port1_upper_pin_config_reg <= BPIO_CFG_RESET[BPIO_P1_UPPER_USED_W-1:0];
      port1_lower_pin_config_reg <= BPIO_CFG_RESET;
      port2_pin_config_reg <= {BPIO_CFG_RESET, BPIO_CFG_RESET};
      port3_pin_config_reg <= {BPIO_CFG_RESET, BPIO_CFG_RESET};
      port1_irq_enable_reg <= BPIO_IRQ_RESET;
    end else if (reg_wr_en) begin
      case (reg_addr)
        BPIO_PORT0_CFG_ADDR: port0_pin_config_reg <= reg_wr_data;
        // upper bits are unused and not stored
        BPIO_PORT1_UPPER_CFG_ADDR: port1_upper_pin_config_reg <= reg_wr_data[BPIO_P1_UPPER_USED_W-1:0];
        BPIO_PORT1_LOWER_CFG_ADDR: port1_lower_pin_config_reg <= reg_wr_data;
        BPIO_PORT1_IRQ_EN_ADDR: port1_irq_enable_reg <= reg_wr_data[BPIO_IRQ_PINS-1:0];
        BPIO_PORT2_UPPER_CFG_ADDR: port2_pin_config_reg[15:8] <= reg_wr_data;
        BPIO_PORT2_LOWER_CFG_ADDR: port2_pin_config_reg[7:0] <= reg_wr_data;
        BPIO_PORT3_UPPER_CFG_ADDR: port3_pin_config_reg[15:8] <= reg_wr_data;
        BPIO_PORT3_LOWER_CFG_ADDR: port3_pin_config_reg[7:0] <= reg_wr_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port0_data_reg <= BPIO_DATA_RESET[P0_W-1:0];
      port1_data_reg <= BPIO_DATA_RESET[P1_W-1:0];
      port2_data_reg <= BPIO_DATA_RESET[P2_W-1:0];
      port3_data_reg <= BPIO_DATA_RESET[P3_W-1:0];
    end else if (reg_wr_en) begin
      case (reg_addr)
        BPIO_PORT0_DATA_ADDR: port0_data_reg <= reg_wr_data[P0_W-1:0];
        BPIO_PORT1_DATA_ADDR: port1_data_reg <= reg_wr_data[P1_W-1:0];
        BPIO_PORT2_DATA_ADDR: port2_data_reg <= reg_wr_data[P2_W-1:0];
        BPIO_PORT3_DATA_ADDR: port3_data_reg <= reg_wr_data[P3_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port0_sync1_reg <= '0;
      port0_sync2_reg <= '0;
      port1_sync1_reg <= '0;
      port1_sync2_reg <= '0;
      port1_prev_reg <= '0;
      port2_sync1_reg <= '0;
      port2_sync2_reg <= '0;
      port3_sync1_reg <= '0;
      port3_sync2_reg <= '0;
    end else begin
      port0_sync1_reg <= port0_pin_in;
      port0_sync2_reg <= port0_sync1_reg;
      port1_sync1_reg <= port1_pin_in;
      port1_sync2_reg <= port1_sync1_reg;
      port1_prev_reg <= port1_sync2_reg;
      port2_sync1_reg <= port2_pin_in;
      port2_sync2_reg <= port2_sync1_reg;
      port3_sync1_reg <= port3_pin_in;
      port3_sync2_reg <= port3_sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // port 1 edge interrupts
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < BPIO_IRQ_PINS; i++) begin
      // either edge on an enabled pin that is in an interrupt input mode
      irq_edge[i] = port1_irq_enable_reg[i] && (bpio_field(port1_cfg_word, i) <= BPIO_MODE_PULLUP)
                    && (port1_sync2_reg[i] != port1_prev_reg[i]);
      pending_next[i] = port1_irq_pending_reg[i];
      if (reg_wr_en && reg_addr == BPIO_PORT1_IRQ_PEND_ADDR && !reg_wr_data[i]) begin
        pending_next[i] = 1'b0;
      end
      if (irq_edge[i]) begin
        pending_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port1_irq_pending_reg <= BPIO_IRQ_RESET;
      external_irq_n <= '1;
    end else begin
      port1_irq_pending_reg <= pending_next;
      external_irq_n <= ~pending_next;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_next = BPIO_READ_IDLE;
    case (reg_addr)
      BPIO_PORT0_DATA_ADDR: begin
        for (int i = 0; i < P0_W; i++) begin
          rd_data_next[i] = (bpio_field(port0_cfg_word, i) == BPIO_MODE_PUSHPULL) ?
                            port0_data_reg[i] : port0_sync2_reg[i];
        end
      end
      BPIO_PORT1_DATA_ADDR: begin
        for (int i = 0; i < P1_W; i++) begin
          rd_data_next[i] = (bpio_field(port1_cfg_word, i) == BPIO_MODE_PUSHPULL) ?
                            port1_data_reg[i] : port1_sync2_reg[i];
        end
      end
      BPIO_PORT2_DATA_ADDR: begin
        for (int i = 0; i < P2_W; i++) begin
          rd_data_next[i] = (bpio_field(port2_pin_config_reg, i) == BPIO_MODE_PUSHPULL) ?
                            port2_data_reg[i] : port2_sync2_reg[i];
        end
      end
      BPIO_PORT3_DATA_ADDR: begin
        for (int i = 0; i < P3_W; i++) begin
          rd_data_next[i] = (bpio_field(port3_pin_config_reg, i) == BPIO_MODE_PUSHPULL) ?
                            port3_data_reg[i] : port3_sync2_reg[i];
        end
      end
      BPIO_PORT0_CFG_ADDR: rd_data_next = port0_pin_config_reg;
      BPIO_PORT1_UPPER_CFG_ADDR: rd_data_next[BPIO_P1_UPPER_USED_W-1:0] = port1_upper_pin_config_reg;
      BPIO_PORT1_LOWER_CFG_ADDR: rd_data_next = port1_lower_pin_config_reg;
      BPIO_PORT1_IRQ_EN_ADDR: rd_data_next[BPIO_IRQ_PINS-1:0] = port1_irq_enable_reg;
      BPIO_PORT1_IRQ_PEND_ADDR: rd_data_next[BPIO_IRQ_PINS-1:0] = port1_irq_pending_reg;
      BPIO_PORT2_UPPER_CFG_ADDR: rd_data_next = port2_pin_config_reg[15:8];
      BPIO_PORT2_LOWER_CFG_ADDR: rd_data_next = port2_pin_config_reg[7:0];
      BPIO_PORT3_UPPER_CFG_ADDR: rd_data_next = port3_pin_config_reg[15:8];
      BPIO_PORT3_LOWER_CFG_ADDR: rd_data_next = port3_pin_config_reg[7:0];
      default: rd_data_next = BPIO_READ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rd_data <= BPIO_READ_IDLE;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port0_pin_out <= '0;
      port0_pin_oe <= '0;
      port0_pullup_en <= '0;
      analog_channels_low_en <= '0;
    end else begin
      for (int i = 0; i < P0_W; i++) begin
        port0_pin_out[i] <= port0_data_reg[i];
        port0_pin_oe[i] <= bpio_field(port0_cfg_word, i) == BPIO_MODE_PUSHPULL;
        port0_pullup_en[i] <= bpio_field(port0_cfg_word, i) == BPIO_MODE_PULLUP;
        analog_channels_low_en[i] <= bpio_field(port0_cfg_word, i) == BPIO_MODE_ALT;
      end
    end
  end

  // port 1: pins 0, 1, 3 have peripheral outputs; 2 has none; 4, 5 go analog
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port1_pin_out <= '0;
      port1_pin_oe <= '0;
      port1_pullup_en <= '0;
      analog_channel_5_en <= 1'b0;
      analog_channel_6_en <= 1'b0;
    end else begin
      for (int i = 0; i < P1_W; i++) begin
        port1_pullup_en[i] <= bpio_field(port1_cfg_word, i) == BPIO_MODE_PULLUP;
        port1_pin_out[i] <= port1_data_reg[i];
        port1_pin_oe[i] <= bpio_field(port1_cfg_word, i) == BPIO_MODE_PUSHPULL;
      end
      if (bpio_field(port1_cfg_word, 0) == BPIO_MODE_ALT) begin
        port1_pin_out[0] <= timer_a_output;
        port1_pin_oe[0] <= 1'b1;
      end
      if (bpio_field(port1_cfg_word, 1) == BPIO_MODE_ALT) begin
        port1_pin_out[1] <= buzzer_output;
        port1_pin_oe[1] <= 1'b1;
      end
      if (bpio_field(port1_cfg_word, 3) == BPIO_MODE_ALT) begin
        port1_pin_out[3] <= timer1_output_zero;
        port1_pin_oe[3] <= 1'b1;
      end
      analog_channel_5_en <= bpio_field(port1_cfg_word, 4) == BPIO_MODE_ALT;
      analog_channel_6_en <= bpio_field(port1_cfg_word, 5) == BPIO_MODE_ALT;
    end
  end

  // peripheral inputs see the pin only while it is in an input mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_a_clock_input <= 1'b0;
      timer_a_capture_input <= 1'b0;
      timer1_clock_input <= 1'b0;
      timer1_capture_input <= 1'b0;
    end else begin
      timer_a_clock_input <= (bpio_field(port1_cfg_word, 1) <= BPIO_MODE_PULLUP) && port1_sync2_reg[1];
      timer_a_capture_input <= (bpio_field(port1_cfg_word, 2) <= BPIO_MODE_PULLUP) && port1_sync2_reg[2];
      timer1_clock_input <= (bpio_field(port1_cfg_word, 4) <= BPIO_MODE_PULLUP) && port1_sync2_reg[4];
      timer1_capture_input <= (bpio_field(port1_cfg_word, 5) <= BPIO_MODE_PULLUP) && port1_sync2_reg[5];
    end
  end

  // port 2 code 11 hands the pin to a peripheral output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port2_pin_out <= '0;
      port2_pin_oe <= '0;
      port2_pullup_en <= '0;
    end else begin
      for (int i = 0; i < P2_W; i++) begin
        port2_pullup_en[i] <= bpio_field(port2_pin_config_reg, i) == BPIO_MODE_PULLUP;
        port2_pin_oe[i] <= (bpio_field(port2_pin_config_reg, i) >= BPIO_MODE_PUSHPULL);
        port2_pin_out[i] <= (bpio_field(port2_pin_config_reg, i) == BPIO_MODE_ALT) ?
                            port2_alt_out[i] : port2_data_reg[i];
      end
    end
  end

  // port 3 code 11 is open drain: drive low only, release for a one
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port3_pin_out <= '0;
      port3_pin_oe <= '0;
      port3_pullup_en <= '0;
    end else begin
      for (int i = 0; i < P3_W; i++) begin
        port3_pullup_en[i] <= bpio_field(port3_pin_config_reg, i) == BPIO_MODE_PULLUP;
        case (bpio_field(port3_pin_config_reg, i))
          BPIO_MODE_PUSHPULL: begin
            port3_pin_out[i] <= port3_data_reg[i];
            port3_pin_oe[i] <= 1'b1;
          end
          BPIO_MODE_ALT: begin
            port3_pin_out[i] <= 1'b0;
            port3_pin_oe[i] <= !port3_data_reg[i];
          end
          default: begin
            port3_pin_out[i] <= port3_data_reg[i];
            port3_pin_oe[i] <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : bpio_ports

`default_nettype wire

// [testbench/bpio_ports_props.sv]
// checker for the port block: register decode, pin drive, port 1 interrupts
// assumes a bind onto bpio_ports with its default port widths
`timescale 1ns/1ps
`default_nettype none

module bpio_ports_props
  import bpio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic [3:0] port0_pin_out,
  input wire logic [3:0] port0_pin_oe,
  input wire logic [3:0] port0_pullup_en,
  input wire logic [3:0] analog_channels_low_en,
  input wire logic [5:0] port1_pin_in,
  input wire logic [BPIO_IRQ_PINS-1:0] external_irq_n
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic cfg_wr;
  logic dat_wr;
  logic pnd_wr;
  assign cfg_wr = reg_wr_en && reg_addr == BPIO_PORT0_CFG_ADDR;
  assign dat_wr = reg_wr_en && reg_addr == BPIO_PORT0_DATA_ADDR;
  assign pnd_wr = reg_wr_en && reg_addr == BPIO_PORT1_IRQ_PEND_ADDR;

  function automatic logic [3:0] pick(input logic [7:0] c, input logic [1:0] m);
    for (int i = 0; i < 4; i++) pick[i] = c[2*i+:2] == m;
  endfunction : pick

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  cfg_decode_a: assert property (
    cfg_wr ##1 !cfg_wr |=> port0_pin_oe == pick($past(reg_wr_data, 2), BPIO_MODE_PUSHPULL)
      && port0_pullup_en == pick($past(reg_wr_data, 2), BPIO_MODE_PULLUP)
      && analog_channels_low_en == pick($past(reg_wr_data, 2), BPIO_MODE_ALT))
    else $error("port 0 pin controls do not follow config");
  reset_vals_a: assert property (
    $rose(resetn) |-> port0_pin_oe == 4'h0 && analog_channels_low_en == 4'h0 && external_irq_n == 4'hF)
    else $error("outputs not at reset state");
  unmapped_read_a: assert property (
    reg_rd_en && !(reg_addr inside {8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE6, 8'hE8, 8'hE9, 8'hEA, 8'hEB,
      8'hF6, 8'hF7, 8'hFC, 8'hFD}) |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  read_pend_a: assert property (
    reg_rd_en && reg_addr == BPIO_PORT1_IRQ_PEND_ADDR |=> reg_rd_data == {4'h0, ~$past(external_irq_n)})
    else $error("pending read differs from request lines");
  data_drive_a: assert property (
    dat_wr ##1 !dat_wr |=> port0_pin_oe != 4'hF || port0_pin_out == $past(reg_wr_data[3:0], 2))
    else $error("output pins do not drive written data");
  mode_excl_a: assert property (
    (port0_pin_oe & (port0_pullup_en | analog_channels_low_en)) == 4'h0)
    else $error("output pin also in another mode");
  for (genvar k = 0; k < 4; k++) begin : g_irq
    irq_set_a: assert property (
      $fell(external_irq_n[k]) |-> $past(port1_pin_in[k], 3) != $past(port1_pin_in[k], 4))
      else $error("request without pin edge");
    irq_clear_a: assert property (
      $rose(external_irq_n[k]) |-> $past(pnd_wr && !reg_wr_data[k]))
      else $error("request released without clearing write");
    irq_hold_a: assert property (
      !external_irq_n[k] && !pnd_wr |=> !external_irq_n[k])
      else $error("request dropped on its own");
  end
endmodule : bpio_ports_props

`default_nettype wire

// [testbench/bpio_pin_model.sv]
// pad model: resolves each pin from block drive, outside driver and pull-up
// assumes an undriven pin without pull-up floats to a changing level
`timescale 1ns/1ps
`default_nettype none

module bpio_pin_model #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pullup_en,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_in
);
  logic [W-1:0] last_reg = '0;
  always @(posedge ref_clk) begin
    last_reg <= pin_in;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_reg[i];
    end
  end
endmodule : bpio_pin_model

`default_nettype wire

// [testbench/tb_top.sv]
// testbench for the port block: register strobes, pin modes, port 1 interrupts
// assumes pin models close every port; read results checked from a queue
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import bpio_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, rd_seen = 1'b0;
  logic [3:0] p0_in, p0_out, p0_oe, p0_pu, an_lo, irq_n, p0_ext = 4'h0, p0_ext_en = 4'hF;
  logic [5:0] p1_in, p1_out, p1_oe, p1_pu, p1_ext = 6'h00;
  logic [7:0] p2_in, p2_out, p2_oe, p2_pu, p3_in, p3_out, p3_oe, p3_pu, p2_ext = 8'h00, p3_ext = 8'h00;
  logic [7:0] p3_ext_en = 8'hFF;
  logic an5, an6, ta_ck, ta_cap, t1_ck, t1_cap;
  logic [10:0] per = 11'h000;
  logic [7:0] exp_q[$];
  int n_errors = 0, checked = 0;

  always #5 ref_clk = ~ref_clk;

  bpio_ports DUT (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .port0_pin_in(p0_in),
    .port0_pin_out(p0_out), .port0_pin_oe(p0_oe), .port0_pullup_en(p0_pu), .analog_channels_low_en(an_lo),
    .port1_pin_in(p1_in), .port1_pin_out(p1_out), .port1_pin_oe(p1_oe), .port1_pullup_en(p1_pu),
    .analog_channel_5_en(an5), .analog_channel_6_en(an6), .timer_a_output(per[0]), .buzzer_output(per[1]),
    .timer1_output_zero(per[2]), .timer_a_clock_input(ta_ck), .timer_a_capture_input(ta_cap),
    .timer1_clock_input(t1_ck), .timer1_capture_input(t1_cap), .external_irq_n(irq_n), .port2_pin_in(p2_in),
    .port2_alt_out(per[10:3]), .port2_pin_out(p2_out), .port2_pin_oe(p2_oe), .port2_pullup_en(p2_pu),
    .port3_pin_in(p3_in), .port3_pin_out(p3_out), .port3_pin_oe(p3_oe), .port3_pullup_en(p3_pu));
  bpio_pin_model #(.W(4)) u_p0 (.ref_clk(ref_clk), .pin_out(p0_out), .pin_oe(p0_oe), .pullup_en(p0_pu),
    .ext_val(p0_ext), .ext_en(p0_ext_en), .pin_in(p0_in));
  bpio_pin_model #(.W(6)) u_p1 (.ref_clk(ref_clk), .pin_out(p1_out), .pin_oe(p1_oe), .pullup_en(p1_pu),
    .ext_val(p1_ext), .ext_en(6'h3F), .pin_in(p1_in));
  bpio_pin_model #(.W(8)) u_p2 (.ref_clk(ref_clk), .pin_out(p2_out), .pin_oe(p2_oe), .pullup_en(p2_pu),
    .ext_val(p2_ext), .ext_en(p3_ext_en), .pin_in(p2_in));
  bpio_pin_model #(.W(8)) u_p3 (.ref_clk(ref_clk), .pin_out(p3_out), .pin_oe(p3_oe), .pullup_en(p3_pu),
    .ext_val(p3_ext), .ext_en(p3_ext_en), .pin_in(p3_in));

  // ----------------------------------------------------------------
  // bus tasks, read monitor and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // strobes stay up until the next call, so back-to-back cycles need no gap
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = w;
    reg_rd_en = r;
    reg_addr = a;
    reg_wr_data = d;
    if (r) exp_q.push_back(d);
  endtask : acc

  task automatic idle(input int n);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0) check(reg_rd_data, exp_q.pop_front());
    rd_seen <= reg_rd_en;
  end

  initial begin
    #50000;
    n_errors++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d, v;
    logic [1:0] c;
    logic [3:0] m;
    void'($urandom(2));
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    check(8'(irq_n), 8'h0F);
    acc(0, 1, 8'hE6, 8'h00);
    acc(0, 1, 8'hE8, 8'h00);
    acc(0, 1, 8'hE9, 8'h00);
    acc(0, 1, 8'hEA, 8'h00);
    acc(1, 1, 8'hE4, 8'h00);
    acc(0, 1, 8'hE4, 8'h00);
    idle(2);
    $display("reset values test done");
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      d = 8'($urandom);
      v = 8'($urandom);
      p0_ext = v[3:0];
      p0_ext_en = (c == 2'h1) ? 4'h0 : 4'hF;
      p1_ext = v[5:0];
      p2_ext = d;
      p3_ext = 8'($urandom);
      p3_ext_en = (c == 2'h1) ? 8'hF0 : 8'hFF;
      per = 11'($urandom); // peripherals run as if enabled for their pins
      acc(1, 0, 8'hE6, {4{c}});
      acc(1, 0, 8'hE8, {4'h0, c, c}); // upper bits kept clear
      acc(1, 0, 8'hE9, {4{c}});
      acc(1, 0, 8'hF7, {4{c}});
      acc(1, 0, 8'hFD, {4{c}});
      acc(1, 0, 8'hE0, d);
      acc(1, 0, 8'hE2, d);
      acc(1, 0, 8'hE3, d);
      idle(4);
      check(8'(p0_oe), (c == 2'h2) ? 8'h0F : 8'h00);
      check(8'(p0_pu), (c == 2'h1) ? 8'h0F : 8'h00);
      check(8'(an_lo), (c == 2'h3) ? 8'h0F : 8'h00);
      check(8'({an6, an5}), (c == 2'h3) ? 8'h03 : 8'h00);
      check(8'({t1_cap, t1_ck}), c[1] ? 8'h00 : 8'(v[5:4]));
      check(8'({ta_cap, ta_ck}), c[1] ? 8'h00 : 8'(v[2:1]));
      check(8'(p1_oe[0]), 8'(c[1]));
      check(8'(p1_out[0]), (c == 2'h3) ? 8'(per[0]) : 8'h00);
      check(8'(p3_oe[3:0]), (c == 2'h2) ? 8'h0F : (c == 2'h3) ? {4'h0, ~d[3:0]} : 8'h00);
      check({p2_oe[3:0], p2_out[3:0]}, {(c[1] ? 4'hF : 4'h0), ((c == 2'h3) ? per[6:3] : d[3:0])});
      check({p3_out[3:0], 1'b0, p1_pu[5], p2_pu[0], p3_pu[0]},
            {(c == 2'h3) ? 4'h0 : d[3:0], 1'b0, {3{c == 2'h1}}});
      acc(0, 1, 8'hE0, (c == 2'h2) ? 8'(d[3:0]) : (c == 2'h1) ? 8'h0F : 8'(v[3:0]));
      acc(0, 1, 8'hE3, {p3_ext[7:4], (c == 2'h2) ? d[3:0] : (c == 2'h1) ? 4'hF :
          (c == 2'h3) ? (d[3:0] & p3_ext[3:0]) : p3_ext[3:0]});
      acc(0, 1, 8'hE6, {4{c}});
      acc(0, 1, 8'hE8, {4'h0, c, c});
      if (!c[1]) acc(0, 1, 8'hE1, {2'h0, v[5:0]});
      idle(2);
    end
    $display("pin mode test done");
    acc(1, 0, 8'hE9, 8'h00);
    acc(1, 0, 8'hF7, 8'h00);
    acc(1, 0, 8'hEA, 8'h05);
    idle(2);
    p1_ext = p1_ext ^ 6'h0F;
    idle(6);
    check(8'(irq_n), 8'h0A);
    acc(0, 1, 8'hEB, 8'h05);
    acc(1, 0, 8'hEB, 8'hFF);
    acc(1, 0, 8'hEB, 8'hFE);
    idle(2);
    check(8'(irq_n), 8'h0B);
    acc(1, 0, 8'hEA, 8'h0E);
    acc(0, 1, 8'hEA, 8'h0E);
    acc(1, 0, 8'hEB, 8'h00);
    for (int i = 0; i < 8; i++) begin
      m = 4'($urandom);
      idle(1);
      p1_ext[3:0] = p1_ext[3:0] ^ m;
      idle(6);
      check(8'(irq_n), {4'h0, ~(m & 4'hE)});
      acc(0, 1, 8'hEB, {4'h0, m & 4'hE});
      acc(1, 0, 8'hEB, 8'h00);
    end
    idle(6);
    acc(0, 1, 8'hEB, 8'h00);
    $display("interrupt test done");
    acc(1, 0, 8'hE6, 8'hAA);
    idle(3);
    resetn = 1'b0;
    idle(2);
    check(8'(p0_oe), 8'h00);
    resetn = 1'b1;
    acc(0, 1, 8'hE6, 8'h00);
    idle(3);
    $display("second reset test done");
    end_sim;
  end
endmodule : tb_top

bind bpio_ports bpio_ports_props u_props (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .port0_pin_out(port0_pin_out), .port0_pin_oe(port0_pin_oe), .port0_pullup_en(port0_pullup_en),
  .analog_channels_low_en(analog_channels_low_en), .port1_pin_in(port1_pin_in), .external_irq_n(external_irq_n));

`default_nettype wire
